//--- logic/count_step.sv
`timescale 1ns/1ns
module count_step #(
  parameter logic [7:0] LO = 8'h00,
  parameter logic [7:0] HI = 8'h3b
) (
  input  wire logic [7:0] value_i,
  input  wire logic       bcd_en_i,
  output logic      [7:0] next_o,
  output logic            at_max_o
);

  // ==========================================================
  // limits in both encodings
  function automatic logic [7:0] to_bcd(input logic [7:0] b);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = b / 8'd10;
    ones = b - tens * 8'd10;
    to_bcd = {tens[3:0], ones[3:0]};
  endfunction : to_bcd

  localparam logic [7:0] LO_BCD = to_bcd(LO);
  localparam logic [7:0] HI_BCD = to_bcd(HI);

  // ==========================================================
  // increment with wrap
  always_comb begin
    at_max_o = bcd_en_i ? (value_i == HI_BCD) : (value_i == HI);
    if (at_max_o) begin
      next_o = bcd_en_i ? LO_BCD : LO;
    end else if (bcd_en_i && value_i[3:0] >= 4'h9) begin
      next_o = {value_i[7:4] + 4'h1, 4'h0};
    end else if (bcd_en_i) begin
      next_o = {value_i[7:4], value_i[3:0] + 4'h1};
    end else begin
      next_o = value_i + 8'h01;
    end
  end

endmodule : count_step

//--- logic/rtc_count_pkg.sv
package rtc_count_pkg;

  // ==========================================================
  // register map on the 8-bit i/o bus
  localparam int          NUM_COUNTS   = 5;
  localparam logic [7:0]  ADDR_SEC     = 8'he0;
  localparam logic [7:0]  ADDR_MIN     = 8'he1;
  localparam logic [7:0]  ADDR_HRS     = 8'he2;
  localparam logic [7:0]  ADDR_WEEKDAY = 8'he3;
  localparam logic [7:0]  ADDR_MONDAY  = 8'he4;
  localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

  // ==========================================================
  // field indices into the count array
  localparam int          IDX_SEC      = 0;
  localparam int          IDX_MIN      = 1;
  localparam int          IDX_HRS      = 2;
  localparam int          IDX_WEEKDAY  = 3;
  localparam int          IDX_MONDAY   = 4;

  // ==========================================================
  // binary limits of each count
  localparam logic [7:0]  SEC_LO       = 8'h00;
  localparam logic [7:0]  SEC_HI       = 8'h3b;
  localparam logic [7:0]  MIN_LO       = 8'h00;
  localparam logic [7:0]  MIN_HI       = 8'h3b;
  localparam logic [7:0]  HRS_LO       = 8'h00;
  localparam logic [7:0]  HRS_HI       = 8'h17;
  localparam logic [7:0]  WEEKDAY_LO   = 8'h01;
  localparam logic [7:0]  WEEKDAY_HI   = 8'h07;
  localparam logic [7:0]  MONDAY_LO    = 8'h01;
  localparam logic [7:0]  MONDAY_HI    = 8'h1f;

  // ==========================================================
  // weekday reserved nibble
  localparam logic [3:0]  WEEKDAY_RSVD = 4'h0;

  // ==========================================================
  // one-second divider, in oscillator ticks
  localparam int          SECOND_DIV   = 32768;

endpackage : rtc_count_pkg

//--- logic/rtc_time_count_registers.sv
// Contract
// - host reaches each count as a byte via i/o read/write cycles
// - unlock high: counting halts, counts readable and writable
// - unlock low: counting runs, host writes ignored
// - reset leaves block locked with counting enabled
// - reset keeps counts; only weekday upper nibble is reset
// - bcd bit selects packed bcd, else plain binary
// - bcd seconds: tens 0-5 high nibble, ones 0-9 low
// - binary seconds range 0x00 to 0x3b
// - bcd minutes: tens 0-5 high nibble, ones 0-9 low
// - binary minutes range 0x00 to 0x3b
// - bcd hours: tens 0-2 high nibble, ones 0-9 low
// - binary hours range 0x00 to 0x17
// - weekday counts 1 to 7 in low nibble, never 0
// - weekday upper nibble read-only zero; host writes zeros
// - bcd monthday: tens 0-3 high nibble, ones 0-9 low
// - binary monthday range 0x01 to 0x1f
// - monthday starts at 1, also after wrap
// - counts advance once per second from the divider
// - unlocking holds the divider cleared; relocking restarts it from zero
`timescale 1ns/1ns
module rtc_time_count_registers
  import rtc_count_pkg::*;
#(
  parameter int SEC_DIV = SECOND_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       count_unlock_i,
  input  wire logic       bcd_en_i,
  input  wire logic       osc_tick_i,
  output logic      [7:0] io_rdata_o,
  output logic            sec_tick_o
);

  localparam logic [7:0] LO_TAB [NUM_COUNTS] =
    '{SEC_LO, MIN_LO, HRS_LO, WEEKDAY_LO, MONDAY_LO};
  localparam logic [7:0] HI_TAB [NUM_COUNTS] =
    '{SEC_HI, MIN_HI, HRS_HI, WEEKDAY_HI, MONDAY_HI};

  logic [7:0] cnt_ff  [NUM_COUNTS];
  logic [7:0] nxt_cnt [NUM_COUNTS];
  logic       at_max  [NUM_COUNTS];
  logic       bump    [NUM_COUNTS];
  logic       unlock_ff;
  logic       tick;
  logic [2:0] wr_idx;
  logic       wr_hit;

  // ==========================================================
  // lock state
  // locked after reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      unlock_ff <= 1'b0;
    end else begin
      unlock_ff <= count_unlock_i;
    end
  end

  // ==========================================================
  // one-second tick
  // divider cleared while unlocked
  second_divider #(
    .DIV        (SEC_DIV)
  ) u_div (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .clear_i    (unlock_ff),
    .osc_tick_i (osc_tick_i),
    .sec_tick_o (tick)
  );

  assign sec_tick_o = tick;

  // ==========================================================
  // ripple carry chain
  // carry ripple
  always_comb begin
    bump[IDX_SEC]     = tick && !unlock_ff;
    bump[IDX_MIN]     = bump[IDX_SEC] && at_max[IDX_SEC];
    bump[IDX_HRS]     = bump[IDX_MIN] && at_max[IDX_MIN];
    bump[IDX_WEEKDAY] = bump[IDX_HRS] && at_max[IDX_HRS];
    bump[IDX_MONDAY]  = bump[IDX_HRS] && at_max[IDX_HRS];
  end

  // ==========================================================
  // write decode
  // byte i/o decode
  always_comb begin
    wr_idx = 3'(io_addr_i - ADDR_SEC);
    wr_hit = io_wr_i && (io_addr_i >= ADDR_SEC)
             && (io_addr_i <= ADDR_MONDAY);
  end

  // ==========================================================
  // per-field counters
  // limits per format
  genvar g;
  generate
    for (g = 0; g < NUM_COUNTS; g++) begin : g_cnt
      count_step #(
        .LO       (LO_TAB[g]),
        .HI       (HI_TAB[g])
      ) u_step (
        .value_i  (cnt_ff[g]),
        .bcd_en_i (bcd_en_i),
        .next_o   (nxt_cnt[g]),
        .at_max_o (at_max[g])
      );

      always_ff @(posedge clk_i) begin
        if (reset_i && g == IDX_WEEKDAY) begin
          cnt_ff[g][7:4] <= WEEKDAY_RSVD;
        end else if (unlock_ff && wr_hit && wr_idx == 3'(g)) begin
          cnt_ff[g] <= (g == IDX_WEEKDAY)
                       ? {WEEKDAY_RSVD, io_wdata_i[3:0]} : io_wdata_i;
        end else if (bump[g]) begin
          cnt_ff[g] <= nxt_cnt[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // read data, registered
  // byte read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      io_rdata_o <= UNMAPPED_VAL;
    end else if (io_rd_i) begin
      case (io_addr_i)
        ADDR_SEC:     io_rdata_o <= cnt_ff[IDX_SEC];
        ADDR_MIN:     io_rdata_o <= cnt_ff[IDX_MIN];
        ADDR_HRS:     io_rdata_o <= cnt_ff[IDX_HRS];
        ADDR_WEEKDAY: io_rdata_o <= {WEEKDAY_RSVD,
                                     cnt_ff[IDX_WEEKDAY][3:0]};
        ADDR_MONDAY:  io_rdata_o <= cnt_ff[IDX_MONDAY];
        default:      io_rdata_o <= UNMAPPED_VAL;
      endcase
    end else begin
      io_rdata_o <= UNMAPPED_VAL;
    end
  end

endmodule : rtc_time_count_registers

//--- logic/second_divider.sv
`timescale 1ns/1ns
module second_divider #(
  parameter int DIV = 32768
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic clear_i,
  input  wire logic osc_tick_i,
  output logic      sec_tick_o
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_ff;

  // ==========================================================
  // divider, held at zero while cleared
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      div_ff <= '0;
    end else if (osc_tick_i) begin
      div_ff <= (div_ff == LAST) ? '0 : div_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      sec_tick_o <= 1'b0;
    end else begin
      sec_tick_o <= osc_tick_i && (div_ff == LAST);
    end
  end

endmodule : second_divider

//--- tb/rtc_count_asserts.sv
`timescale 1ns/1ns
module rtc_count_asserts
  import rtc_count_pkg::*;
#(
  parameter int SEC_DIV = SECOND_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       count_unlock_i,
  input  wire logic       osc_tick_i,
  input  wire logic [7:0] io_rdata_o,
  input  wire logic       sec_tick_o
);
  // ====
  // bus and tick relations
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rd_idle; !io_rd_i |=> io_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("data without read");
  property p_unmap;
    io_rd_i && (io_addr_i < ADDR_SEC || io_addr_i > ADDR_MONDAY)
      |=> io_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_wd_hi;
    io_rd_i && io_addr_i == ADDR_WEEKDAY |=> io_rdata_o[7:4] == 4'h0;
  endproperty
  a_wd_hi: assert property (p_wd_hi)
    else $error("weekday upper bits set");
  property p_tick_osc; sec_tick_o |-> $past(osc_tick_i); endproperty
  a_tick_osc: assert property (p_tick_osc)
    else $error("tick without oscillator");
  property p_tick_gap; sec_tick_o |=> !sec_tick_o [*3]; endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("ticks too close");
  property p_tick_lock; sec_tick_o |-> !$past(count_unlock_i, 2); endproperty
  a_tick_lock: assert property (p_tick_lock)
    else $error("tick while unlocked");
  property p_relock; $fell(count_unlock_i) |=> !sec_tick_o [*3]; endproperty
  a_relock: assert property (p_relock)
    else $error("early tick after relock");
  property p_rst_quiet;
    $fell(reset_i) |-> !sec_tick_o && io_rdata_o == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs busy after reset");
  c_tick: cover property (sec_tick_o);
  c_wd: cover property (io_rd_i && io_addr_i == ADDR_WEEKDAY);
  c_relock: cover property ($fell(count_unlock_i));
endmodule : rtc_count_asserts

bind rtc_time_count_registers rtc_count_asserts #(.SEC_DIV(SEC_DIV))
  i_rtc_count_asserts (
  .clk_i, .reset_i, .io_addr_i, .io_rd_i, .count_unlock_i,
  .osc_tick_i, .io_rdata_o, .sec_tick_o);

//--- tb/rtc_time_count_registers_bench.sv
`timescale 1ns/1ns
module rtc_time_count_registers_bench;
  import rtc_count_pkg::*;
  // ====
  // signals and model state
  logic        clk_i, reset_i, io_rd_i, io_wr_i, sec_tick_o;
  logic        count_unlock_i, bcd_en_i, osc_tick_i;
  logic [7:0]  io_addr_i, io_wdata_i, io_rdata_o;
  logic [31:0] rs = 32'h956e;
  int          errors, n_checks, i, f, m[5];
  int          hb[5] = '{'h3b, 'h3b, 'h17, 7, 'h1f};
  int          hd[5] = '{'h59, 'h59, 'h23, 7, 'h31};
  int          lo[5] = '{0, 0, 0, 1, 1};

  localparam int DIV = 4;

  rtc_time_count_registers #(.SEC_DIV(DIV)) i_rtc_time_count_registers (
    .clk_i, .reset_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i,
    .count_unlock_i, .bcd_en_i, .osc_tick_i, .io_rdata_o, .sec_tick_o);

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ====
  // model and bus tasks
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd

  function automatic int nx(int k);
    int h;
    h = bcd_en_i ? hd[k] : hb[k];
    if (m[k] == h) return lo[k];
    return (bcd_en_i && m[k] % 16 == 9) ? m[k] + 7 : m[k] + 1;
  endfunction : nx

  task automatic step_model();
    bit c;
    c = 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (c) m[k] = nx(k);
      if (k < 3) c = c && m[k] == lo[k];
    end
  endtask : step_model

  task automatic final_report();
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic cmp(int k, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD count %0d exp %h got %h", k, e, g);
    end
  endtask : cmp

  task automatic cmp_tick(int e, int g);
    n_checks++;
    if (g != e) begin
      errors++;
      $display("BAD tick_cycles exp %0d got %0d", e, g);
    end
  endtask : cmp_tick

  task automatic wr(int k, int d);
    @(posedge clk_i);
    io_wr_i <= 1'b1;
    io_addr_i <= ADDR_SEC + k[7:0];
    io_wdata_i <= d[7:0];
    @(posedge clk_i);
    io_wr_i <= 1'b0;
    if (count_unlock_i) m[k] = k == IDX_WEEKDAY ? d % 16 : d % 256;
  endtask : wr

  task automatic rd(int k);
    @(posedge clk_i);
    io_rd_i <= 1'b1;
    io_addr_i <= ADDR_SEC + k[7:0];
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    #1 cmp(k, k < 5 ? m[k][7:0] : 8'h00, io_rdata_o);
  endtask : rd

  task automatic run_sec();
    int j;
    @(posedge clk_i);
    osc_tick_i <= 1'b1;
    for (j = 0; j < 20 && sec_tick_o !== 1'b1; j++) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    osc_tick_i <= 1'b0;
    if (j == 20) begin
      errors++;
      final_report();
    end else begin
      cmp_tick(DIV, j);
      step_model();
    end
  endtask : run_sec

  // ====
  // main sequence
  initial begin
    {reset_i, io_rd_i, io_wr_i, osc_tick_i, bcd_en_i} = 5'h10;
    {count_unlock_i, io_addr_i, io_wdata_i} = '0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    count_unlock_i <= 1'b1;
    for (i = 0; i < 5; i++) begin
      f = rnd();
      wr(i, i == IDX_WEEKDAY ? f % 16 : f);
    end
    // oscillator runs while unlocked: counts must hold
    osc_tick_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    osc_tick_i <= 1'b0;
    for (i = 0; i < 5; i++) rd(i);
    for (f = 0; f < 2; f++) begin
      @(posedge clk_i);
      bcd_en_i <= f[0];
      count_unlock_i <= 1'b1;
      for (i = 0; i < 5; i++) wr(i, f ? hd[i] : hb[i]);
      count_unlock_i <= 1'b0;
      wr(0, 0);
      run_sec();
      for (i = 0; i < 5; i++) rd(i);
      @(posedge clk_i);
      count_unlock_i <= 1'b1;
      wr(0, 9);
      count_unlock_i <= 1'b0;
      run_sec();
      rd(0);
    end
    rd(5);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 5; i++) rd(i);
    run_sec();
    rd(0);
    final_report();
  end
endmodule : rtc_time_count_registers_bench
